// ### logic/step_sequencer_regs.vh
// Constants for the multi-step speed sequencer: offsets, fields, defaults and timing.
// Functional notes
// - Mode 0 stops drive after one cycle.
// - Mode 1 holds last step after cycle.
// - Mode 2 repeats cycles until stop.
// - Power-loss retention resumes saved point.
// - Without power retention restart at step zero.
// - Stop retention resumes from recorded point.
// - Without stop retention restart at step zero.
// - Output targets frequency reference, voltage reference or PID setpoint.
// - Negative step value means reverse direction; the code asserts reverse only for the frequency target.
// - Sixteen signed step values, 0.1 percent.
// - Frequency output scaled by maximum frequency.
// - Voltage output scaled by rated voltage.
// - PID setpoint passes percentage unscaled.
// - Terminal states may select active step.
// - Step duration 0.0 to 6500.0, 0.1 units.
// - Per-step two-bit ramp set selector.
// - Time unit seconds or hours.
// - Step zero source selectable, seven choices.
`ifndef STEP_SEQUENCER_REGS_VH
`define STEP_SEQUENCER_REGS_VH
// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_MODE 8'h00
`define ADDR_RETAIN 8'h01
`define ADDR_UNIT 8'h02
`define ADDR_SRC0 8'h03
`define ADDR_TARGET 8'h04
`define ADDR_MAXFREQ 8'h05
`define ADDR_RATEDV 8'h06
`define ADDR_STATUS 8'h07
`define ADDR_ELAPSED 8'h08
`define ADDR_VALUE_BASE 8'h10
`define ADDR_TIME_BASE 8'h20
`define ADDR_RAMP_BASE 8'h30
// ****************************************************************
// Encodings and limits
// ****************************************************************
`define MODE_STOP 2'h0
`define MODE_HOLD 2'h1
`define MODE_REPEAT 2'h2
`define TGT_FREQ 2'h0
`define TGT_VOLT 2'h1
`define TGT_PID 2'h2
`define VALUE_MAX 16'sh03E8
`define VALUE_MIN -16'sh03E8
`define TIME_MAX 16'hFDE8
`define LAST_STEP 4'hF
`define PERMILLE 32'h000003E8
`define CLK_HZ 50000000
`define TICK_MS 100
`define TICKS_PER_TENTH ((`CLK_HZ / 1000) * `TICK_MS)
`define TENTHS_PER_HOUR_SCALE 36'h000000E10
`define HOUR_LAST 12'hE0F
`define MAXFREQ_RST 16'h1388
`define RATEDV_RST 16'h017C
`endif

// ### logic/step_sequencer.v
// Multi-step speed sequencer with per-step timing, ramp selection and output scaling.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`include "step_sequencer_regs.vh"
`default_nettype none
module step_sequencer #(
  parameter TICK_CYCLES = `TICKS_PER_TENTH
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Register port
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Drive commands
  input wire run_cmd,
  input wire stop_cmd,
  input wire power_loss,
  input wire power_up,
  // Terminal step selection
  input wire terminal_sel_en,
  input wire [3:0] terminal_step,
  // Step zero sources, signed 0.1 percent
  input wire [15:0] analog_input_one,
  input wire [15:0] analog_input_two,
  input wire [15:0] analog_input_three,
  input wire [15:0] pulse_input,
  input wire [15:0] pid_output,
  input wire [15:0] keypad_freq,
  // Reference outputs
  output reg running,
  output reg reverse,
  output reg [3:0] active_step,
  output reg [1:0] ramp_set,
  output reg [15:0] freq_ref,
  output reg [15:0] volt_ref,
  output reg [15:0] pid_setpoint,
  output reg cycle_done
);
  // ****************************************************************
  // Configuration storage
  // ****************************************************************
  reg [15:0] value_q [0:15];
  reg [15:0] time_q [0:15];
  reg [1:0] ramp_q [0:15];
  reg [1:0] mode_q;
  reg [1:0] retain_q;
  reg unit_q;
  reg [2:0] src0_q;
  reg [1:0] target_q;
  reg [15:0] maxfreq_q;
  reg [15:0] ratedv_q;
  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  reg [3:0] step_q;
  reg [15:0] tenths_q;
  reg [31:0] tick_q;
  reg [11:0] hour_q;
  reg run_q;
  reg saved_valid_q;
  reg [3:0] saved_step_q;
  reg [15:0] saved_tenths_q;
  reg halted_q;
  wire wr_value = wr && (addr[7:4] == 4'h1);
  wire wr_time = wr && (addr[7:4] == 4'h2);
  wire wr_ramp = wr && (addr[7:4] == 4'h3);
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_step
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          value_q[gi] <= 16'h0000;
          time_q[gi] <= 16'h0000;
          ramp_q[gi] <= 2'h0;
        end else begin
          if (wr_value && addr[3:0] == gi) begin
            // Clamp into the signed plus or minus 100.0 percent range.
            if ($signed(wdata) > `VALUE_MAX)
              value_q[gi] <= `VALUE_MAX;
            else if ($signed(wdata) < `VALUE_MIN)
              value_q[gi] <= `VALUE_MIN;
            else
              value_q[gi] <= wdata;
          end
          if (wr_time && addr[3:0] == gi)
            time_q[gi] <= (wdata > `TIME_MAX) ? `TIME_MAX : wdata;
          if (wr_ramp && addr[3:0] == gi)
            ramp_q[gi] <= wdata[1:0];
        end
      end
    end
  endgenerate
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `MODE_STOP;
      retain_q <= 2'h0;
      unit_q <= 1'b0;
      src0_q <= 3'h0;
      target_q <= `TGT_FREQ;
      maxfreq_q <= `MAXFREQ_RST;
      ratedv_q <= `RATEDV_RST;
    end else if (wr) begin
      case (addr)
        `ADDR_MODE: mode_q <= (wdata[1:0] == 2'h3) ? `MODE_STOP : wdata[1:0];
        `ADDR_RETAIN: retain_q <= wdata[1:0];
        `ADDR_UNIT: unit_q <= wdata[0];
        `ADDR_SRC0: src0_q <= (wdata[2:0] == 3'h7) ? 3'h0 : wdata[2:0];
        `ADDR_TARGET: target_q <= (wdata[1:0] == 2'h3) ? `TGT_FREQ : wdata[1:0];
        `ADDR_MAXFREQ: maxfreq_q <= wdata;
        `ADDR_RATEDV: ratedv_q <= wdata;
        default: mode_q <= mode_q;
      endcase
    end
  end
  // ****************************************************************
  // Step zero source and active value
  // ****************************************************************
  reg [15:0] step0_val;
  always @* begin
    case (src0_q)
      3'h1: step0_val = analog_input_one;
      3'h2: step0_val = analog_input_two;
      3'h3: step0_val = analog_input_three;
      3'h4: step0_val = pulse_input;
      3'h5: step0_val = pid_output;
      3'h6: step0_val = keypad_freq;
      default: step0_val = value_q[0];
    endcase
  end
  // Terminal selection overrides the timed step for the reference value, active_step and ramp_set.
  wire [3:0] sel_step = terminal_sel_en ? terminal_step : step_q;
  wire [15:0] sel_val = (sel_step == 4'h0) ? step0_val : value_q[sel_step];
  // ****************************************************************
  // Time base: one tick per 0.1 s, or per 0.1 h when hours are chosen
  // ****************************************************************
  wire tick_wrap = (tick_q == TICK_CYCLES - 1);
  wire hour_wrap = (hour_q == `HOUR_LAST);
  wire unit_tick = tick_wrap && (!unit_q || hour_wrap);
  wire step_end = run_q && !terminal_sel_en && (tenths_q >= time_q[step_q]);
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 32'h00000000;
      hour_q <= 12'h000;
    end else if (!run_q || halted_q) begin
      tick_q <= 32'h00000000;
      hour_q <= 12'h000;
    end else if (tick_wrap) begin
      tick_q <= 32'h00000000;
      hour_q <= (!unit_q || hour_wrap) ? 12'h000 : hour_q + 12'h001;
    end else begin
      tick_q <= tick_q + 32'h00000001;
    end
  end
  // ****************************************************************
  // Step sequencing and retention
  // ****************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      step_q <= 4'h0;
      tenths_q <= 16'h0000;
      run_q <= 1'b0;
      halted_q <= 1'b0;
      saved_valid_q <= 1'b0;
      saved_step_q <= 4'h0;
      saved_tenths_q <= 16'h0000;
      cycle_done <= 1'b0;
    end else begin
      cycle_done <= 1'b0;
      if (power_loss) begin
        run_q <= 1'b0;
        halted_q <= 1'b0;
        saved_valid_q <= retain_q[0];
        saved_step_q <= step_q;
        saved_tenths_q <= tenths_q;
      end else if (power_up) begin
        // The saved point survives only when power retention is on.
        if (!retain_q[0]) begin
          saved_valid_q <= 1'b0;
          step_q <= 4'h0;
          tenths_q <= 16'h0000;
        end
      end else if (stop_cmd && run_q) begin
        run_q <= 1'b0;
        halted_q <= 1'b0;
        saved_valid_q <= retain_q[1];
        saved_step_q <= step_q;
        saved_tenths_q <= tenths_q;
      end else if (run_cmd && !run_q) begin
        run_q <= 1'b1;
        halted_q <= 1'b0;
        if (saved_valid_q) begin
          step_q <= saved_step_q;
          tenths_q <= saved_tenths_q;
        end else begin
          step_q <= 4'h0;
          tenths_q <= 16'h0000;
        end
      end else if (run_q && !halted_q) begin
        if (step_end) begin
          tenths_q <= 16'h0000;
          if (step_q != `LAST_STEP) begin
            step_q <= step_q + 4'h1;
          end else begin
            cycle_done <= 1'b1;
            saved_valid_q <= 1'b0;
            case (mode_q)
              `MODE_HOLD: halted_q <= 1'b1;
              `MODE_REPEAT: step_q <= 4'h0;
              default: begin
                run_q <= 1'b0;
                step_q <= 4'h0;
              end
            endcase
          end
        end else if (unit_tick) begin
          tenths_q <= tenths_q + 16'h0001;
        end
      end
    end
  end
  // ****************************************************************
  // Output scaling
  // ****************************************************************
  wire neg = sel_val[15];
  wire [15:0] mag = neg ? (16'h0000 - sel_val) : sel_val;
  wire [31:0] fprod = mag * maxfreq_q;
  wire [31:0] vprod = mag * ratedv_q;
  // A magnitude of at most 1000 per mille keeps the quotient inside 16 bits.
  wire [31:0] fquot = fprod / `PERMILLE;
  wire [31:0] vquot = vprod / `PERMILLE;
  wire [15:0] fscaled = fquot[15:0];
  wire [15:0] vscaled = vquot[15:0];
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
      reverse <= 1'b0;
      active_step <= 4'h0;
      ramp_set <= 2'h0;
      freq_ref <= 16'h0000;
      volt_ref <= 16'h0000;
      pid_setpoint <= 16'h0000;
    end else begin
      running <= run_q;
      active_step <= sel_step;
      ramp_set <= ramp_q[sel_step];
      reverse <= run_q && (target_q == `TGT_FREQ) && neg;
      freq_ref <= (run_q && target_q == `TGT_FREQ) ? fscaled : 16'h0000;
      volt_ref <= (run_q && target_q == `TGT_VOLT) ? vscaled : 16'h0000;
      pid_setpoint <= (target_q == `TGT_PID) ? sel_val : 16'h0000;
    end
  end
  // ****************************************************************
  // Register read
  // ****************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr[7:4])
        4'h1: rdata <= value_q[addr[3:0]];
        4'h2: rdata <= time_q[addr[3:0]];
        4'h3: rdata <= {14'h0000, ramp_q[addr[3:0]]};
        4'h0: begin
          case (addr)
            `ADDR_MODE: rdata <= {14'h0000, mode_q};
            `ADDR_RETAIN: rdata <= {14'h0000, retain_q};
            `ADDR_UNIT: rdata <= {15'h0000, unit_q};
            `ADDR_SRC0: rdata <= {13'h0000, src0_q};
            `ADDR_TARGET: rdata <= {14'h0000, target_q};
            `ADDR_MAXFREQ: rdata <= maxfreq_q;
            `ADDR_RATEDV: rdata <= ratedv_q;
            `ADDR_STATUS: rdata <= {9'h000, saved_valid_q, halted_q, run_q, step_q};
            `ADDR_ELAPSED: rdata <= tenths_q;
            default: rdata <= 16'h0000;
          endcase
        end
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ### tb/drive_ref_model.sv
// Behavioural model of the drive reference path fed by the step sequencer.
`default_nettype none
module drive_ref_model (
  // Clock
  input wire logic clock,
  // Sequencer outputs
  input wire logic running,
  input wire logic reverse,
  input wire logic [15:0] freq_ref,
  // Signed speed command applied to the motor
  output var logic signed [16:0] speed_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // A stopped drive ignores the reference, so a stale value never reaches the motor.
  always @(posedge clock) begin
    if (!running) speed_cmd <= 17'h00000;
    else if (reverse) speed_cmd <= -$signed({1'b0, freq_ref});
    else speed_cmd <= $signed({1'b0, freq_ref});
  end
endmodule
`default_nettype wire

// ### tb/step_sequencer_assertions.sv
// Port-level assertions for the step sequencer.
`include "step_sequencer_regs.vh"
`default_nettype none
module step_sequencer_assertions (
  // Clock, reset and register port
  input wire clock,
  input wire reset_n,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  // Commands and sequencer state
  input wire run_cmd,
  input wire stop_cmd,
  input wire power_loss,
  input wire power_up,
  input wire terminal_sel_en,
  input wire running,
  input wire [3:0] active_step,
  input wire cycle_done
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] mode_q;
  wire calm = !stop_cmd && !power_loss && !power_up;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Shadow of the mode register; an illegal code falls back to stop mode.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) mode_q <= 2'h0;
    else if (wr && addr == `ADDR_MODE) mode_q <= (wdata[1:0] == 2'h3) ? 2'h0 : wdata[1:0];
  end
  a_read_idle: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
  a_unmapped_zero: assert property (rd && addr == 8'h0F |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_done_pulse: assert property (cycle_done |=> !cycle_done) else $error("done too long");
  a_step_order: assert property (running && $past(running) && active_step != $past(active_step)
    && !terminal_sel_en && !$past(terminal_sel_en) && !$past(terminal_sel_en, 2)
    && !$past(power_up) |-> active_step == $past(active_step) + 4'h1)
    else $error("step order broken");
  a_mode_stop: assert property (cycle_done && mode_q == `MODE_STOP |-> ##[0:2] !running)
    else $error("mode stop kept running");
  a_mode_hold: assert property (cycle_done && mode_q == `MODE_HOLD && calm
    |-> ##2 (running && active_step == `LAST_STEP) [*3]) else $error("hold lost");
  a_mode_repeat: assert property (cycle_done && mode_q == `MODE_REPEAT && calm
    |-> ##[1:3] (running && active_step == 4'h0)) else $error("repeat missing");
  a_stop_halts: assert property (stop_cmd && !power_loss && !power_up |-> ##[1:3] !running)
    else $error("stop ignored");
  a_run_starts: assert property (run_cmd && !running && calm |-> ##[1:3] running)
    else $error("run ignored");
endmodule
bind step_sequencer step_sequencer_assertions u_chk (.*);
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the step sequencer and the drive reference model.
`include "step_sequencer_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, wr, rd, run_cmd, stop_cmd, power_loss, power_up, terminal_sel_en;
  logic running, reverse, cycle_done;
  logic [7:0] addr;
  logic [3:0] terminal_step, active_step;
  logic [1:0] ramp_set;
  logic [15:0] wdata, rdata, freq_ref, volt_ref, pid_setpoint;
  logic [15:0] src_exp [0:6];
  logic [23:0] rows [0:10];
  logic signed [16:0] speed_cmd;
  int err_total, n_compared;
  wire [15:0] analog_input_one = src_exp[1];
  wire [15:0] analog_input_two = src_exp[2];
  wire [15:0] analog_input_three = src_exp[3];
  wire [15:0] pulse_input = src_exp[4];
  wire [15:0] pid_output = src_exp[5];
  wire [15:0] keypad_freq = src_exp[6];
  step_sequencer #(.TICK_CYCLES(4)) u_dut (.*);
  drive_ref_model u_ref (.clock(clock), .running(running), .reverse(reverse),
    .freq_ref(freq_ref), .speed_cmd(speed_cmd));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Commands are one-cycle pulses; the three idle edges let the registered outputs land.
  task automatic pulse(input int k);
    @(posedge clock);
    {power_up, power_loss, stop_cmd, run_cmd} <= 4'h1 << k;
    @(posedge clock);
    {power_up, power_loss, stop_cmd, run_cmd} <= 4'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  // Bit 4 waits for the end of a cycle, otherwise for the given step.
  task automatic wait_on(input logic [4:0] s);
    int i;
    for (i = 0; i < 40000; i++) begin
      @(posedge clock);
      #1;
      if (s[4] ? cycle_done === 1'b1 : active_step === s[3:0]) break;
    end
    if (i == 40000) begin
      err_total++;
      $display("BAD %0t wait ran out", $time);
      summarize();
    end
  endtask
  task automatic ret_case(input logic [15:0] r, input int k, input logic [3:0] e);
    wr_reg(`ADDR_RETAIN, r);
    pulse(0);
    wait_on(5'h01);
    pulse(k);
    if (k == 2) pulse(3);
    pulse(0);
    chk(active_step, e);
    pulse(1);
  endtask
  initial begin
    {wr, rd, run_cmd, stop_cmd, power_loss, power_up, terminal_sel_en} = '0;
    addr = 8'h00;
    wdata = 16'h0000;
    terminal_step = 4'h1;
    src_exp = '{16'h01F4, 16'h0064, 16'h00C8, 16'h012C, 16'h0190, 16'h0258, 16'h02BC};
    rows = '{24'h000000, 24'h010000, 24'h020000, 24'h030000, 24'h040000, 24'h051388,
      24'h06017C, 24'h100000, 24'h2F0000, 24'h330000, 24'h0F0000};
    reset_n = 1'b0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    foreach (rows[i]) rd_chk(rows[i][23:16], rows[i][15:0]);
    $display("defaults done");
    wr_reg(`ADDR_VALUE_BASE, 16'h01F4);
    wr_reg(`ADDR_VALUE_BASE + 8'h01, 16'hFF06);
    wr_reg(`ADDR_VALUE_BASE + 8'h02, 16'h07D0);
    rd_chk(`ADDR_VALUE_BASE + 8'h02, 16'h03E8);
    wr_reg(`ADDR_TIME_BASE + 8'h03, 16'hFFFF);
    rd_chk(`ADDR_TIME_BASE + 8'h03, 16'hFDE8);
    wr_reg(`ADDR_TIME_BASE + 8'h03, 16'h0000);
    wr_reg(`ADDR_TIME_BASE, 16'h0002);
    wr_reg(`ADDR_TIME_BASE + 8'h01, 16'h0004);
    wr_reg(`ADDR_RAMP_BASE + 8'h01, 16'h0003);
    pulse(0);
    chk({running, reverse, ramp_set, freq_ref}, {4'h8, 16'h09C4});
    chk(speed_cmd, 17'h009C4);
    wait_on(5'h01);
    repeat (2) @(posedge clock);
    #1 chk({running, reverse, ramp_set, freq_ref}, {4'hF, 16'h04E2});
    chk(speed_cmd, 17'h1FB1E);
    pulse(1);
    for (int m = 0; m < 3; m++) begin
      wr_reg(`ADDR_MODE, 16'(m));
      pulse(0);
      wait_on(5'h10);
      repeat (3) @(posedge clock);
      #1 chk(running, m != 0);
      chk(active_step, (m == 1) ? 4'hF : 4'h0);
      pulse(1);
    end
    wr_reg(`ADDR_MODE, 16'h0003);
    rd_chk(`ADDR_MODE, 16'h0000);
    $display("modes done");
    ret_case(16'h0002, 1, 4'h1);
    ret_case(16'h0000, 1, 4'h0);
    ret_case(16'h0001, 2, 4'h1);
    ret_case(16'h0000, 2, 4'h0);
    wr_reg(`ADDR_UNIT, 16'h0001);
    pulse(0);
    repeat (20) @(posedge clock);
    #1 chk(active_step, 4'h0);
    pulse(1);
    wr_reg(`ADDR_UNIT, 16'h0000);
    $display("retention and unit done");
    wr_reg(`ADDR_TIME_BASE, 16'h0064);
    wr_reg(`ADDR_TARGET, 16'h0001);
    pulse(0);
    chk(volt_ref, 16'h00BE);
    wr_reg(`ADDR_TARGET, 16'h0002);
    for (int s = 0; s < 7; s++) begin
      wr_reg(`ADDR_SRC0, 16'(s));
      repeat (2) @(posedge clock);
      #1 chk(pid_setpoint, src_exp[s]);
    end
    @(posedge clock) terminal_sel_en <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({active_step, pid_setpoint}, {4'h1, 16'hFF06});
    @(posedge clock) terminal_sel_en <= 1'b0;
    pulse(1);
    $display("targets done");
    summarize();
  end
endmodule
`default_nettype wire
